// >>> verilog/rct_timer_map.svh
// Purpose: register indices, field positions and reset values of the timers
// Assumes: byte address = 4 * register index, 32-bit APB data
// Notes:   definitions only
`ifndef RCT_TIMER_MAP_SVH
`define RCT_TIMER_MAP_SVH

// register indices
`define RCT_IDX_T2_CONTROL      8'h19
`define RCT_IDX_T2_RELOAD_UPPER 8'h1A
`define RCT_IDX_T2_RELOAD_LOW   8'h1B
`define RCT_IDX_T2_COUNT_HIGH   8'h1C
`define RCT_IDX_T2_COUNT_LOW    8'h1D
`define RCT_IDX_T3_CONTROL      8'h1E
`define RCT_IDX_T3_RELOAD_HIGH  8'h1F
`define RCT_IDX_T3_RELOAD_LOW   8'h20
`define RCT_IDX_T3_COUNT_HIGH   8'h21
`define RCT_IDX_T3_COUNT_LOW    8'h22
`define RCT_IDX_IRQ_STATUS      8'h30
`define RCT_IDX_IRQ_MASK        8'h31
`define RCT_IDX_COMMAND         8'h32

// control register fields
`define RCT_CTL_STOP_RX         7
`define RCT_CTL_START_HI        5
`define RCT_CTL_START_LO        4
`define RCT_CTL_AUTO_RELOAD     3
`define RCT_CTL_CLK_HI          1
`define RCT_CTL_CLK_LO          0
`define RCT_CTL_WRITE_MASK      8'hBB

// start mode codes
`define RCT_START_NONE          2'h0
`define RCT_START_TX_END        2'h1
`define RCT_START_TRIM_NO_UF    2'h2
`define RCT_START_TRIM_UF       2'h3

// clock select codes
`define RCT_CLK_13M56           2'h0
`define RCT_CLK_212K            2'h1
`define RCT_CLK_T0_UF           2'h2
`define RCT_CLK_T1_UF           2'h3

// interrupt status bits and command bits
`define RCT_IRQ_T2_UF           0
`define RCT_IRQ_T3_UF           1
`define RCT_CMD_T2_START        0
`define RCT_CMD_T2_STOP         1
`define RCT_CMD_T3_START        2
`define RCT_CMD_T3_STOP         3

// reset values
`define RCT_RST_BYTE            8'h00
`define RCT_RST_WORD            16'h0000
`define RCT_RST_IRQ             2'h0

`endif

// >>> verilog/rct_pkg.sv
// Purpose: shared types of the reload countdown timers
// Assumes: nothing beyond the map header
// Notes:   constants live in rct_timer_map.svh
package rct_pkg;
  typedef enum logic {RCT_IDLE, RCT_RUN} rct_state_t;
  typedef logic [15:0] rct_word_t;
endpackage

// >>> verilog/rct_tmr_if.sv
// Purpose: carrier between the register block and one countdown core
// Assumes: single pclk domain
// Notes:   start, stop and tick are one-cycle pulses
interface rct_tmr_if;
  import rct_pkg::*;
  logic      start;
  logic      stop;
  logic      tick;
  logic      auto_reload;
  logic      allow_uf;
  rct_word_t reload;
  rct_word_t count;
  logic      running;
  logic      underflow;

  modport ctrl (output start, stop, tick, auto_reload, allow_uf, reload,
                input  count, running, underflow);
  modport core (input  start, stop, tick, auto_reload, allow_uf, reload,
                output count, running, underflow);
endinterface

// >>> verilog/rct_down_counter.sv
// Purpose: one 16-bit down counter with reload and underflow pulse
// Assumes: start wins over stop, stop wins over a tick
// Notes:   underflow is the tick that finds the count at zero
`include "rct_timer_map.svh"
module rct_down_counter
  import rct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  rct_tmr_if.core  tmr
);
  rct_state_t state_ff;
  rct_word_t  count_ff;
  logic       uf_ff;
  logic       at_zero;
  logic       wrap;

  // a tick at zero while running and not overridden by start or stop
  assign at_zero = (state_ff == RCT_RUN) && tmr.tick && (count_ff == 16'h0000)
                   && !tmr.start && !tmr.stop;
  assign wrap    = at_zero && tmr.allow_uf && tmr.auto_reload;

  // count value: reload only at start or auto reload, never on a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= `RCT_RST_WORD;
    end else if (tmr.start) begin
      count_ff <= tmr.reload;
    end else if (wrap) begin
      count_ff <= tmr.reload;
    end else if ((state_ff == RCT_RUN) && tmr.tick && !tmr.stop &&
                 (count_ff != 16'h0000)) begin
      count_ff <= count_ff - 16'h0001;
    end
  end

  // run state; zero is held after a one-shot underflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RCT_IDLE;
    end else begin
      case (state_ff)
        RCT_IDLE: begin
          if (tmr.start) begin
            state_ff <= RCT_RUN;
          end
        end
        RCT_RUN: begin
          if (tmr.start) begin
            state_ff <= RCT_RUN;
          end else if (tmr.stop) begin
            state_ff <= RCT_IDLE;
          end else if (at_zero && !wrap) begin
            state_ff <= RCT_IDLE;
          end
        end
        default: state_ff <= RCT_IDLE;
      endcase
    end
  end

  // underflow pulse, suppressed in trimming without underflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uf_ff <= 1'b0;
    end else begin
      uf_ff <= at_zero && tmr.allow_uf;
    end
  end

  assign tmr.count     = count_ff;
  assign tmr.running   = (state_ff == RCT_RUN);
  assign tmr.underflow = uf_ff;

  a_start_loads: assert property (@(posedge pclk) disable iff (!presetn)
    tmr.start |=> tmr.running && count_ff == $past(tmr.reload))
    else $error("start did not load reload value");
  a_auto_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> uf_ff && tmr.running && count_ff == $past(tmr.reload))
    else $error("auto reload did not wrap");
  a_one_shot: assert property (@(posedge pclk) disable iff (!presetn)
    at_zero && !tmr.auto_reload |=> !tmr.running && count_ff == 16'h0000
    ##1 (count_ff == 16'h0000 || $past(tmr.start)))
    else $error("one shot timer did not stop at zero");
  a_decrement: assert property (@(posedge pclk) disable iff (!presetn)
    tmr.running && tmr.tick && !tmr.start && !tmr.stop && count_ff != 0
    |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("count did not decrement on tick");
endmodule

// >>> verilog/rct_timers.sv
// Purpose: APB register block for the third and fourth countdown timers
// Assumes: all event inputs are one-cycle pulses synchronous to pclk
// Notes:   one core instance per timer, wired through rct_tmr_if
//
// Behaviour
// - third timer low reload byte, used at start
// - third timer live count readable, two bytes
// - stop-on-receive stops after first four bits
// - stop-on-receive ignored in trimming modes
// - start mode field selects start behaviour
// - auto reload restarts countdown at zero, except in trimming without underflow
// - without auto reload stop, hold zero
// - fourth timer underflow sets its flag
// - fourth timer clock select picks tick
// - fourth timer high reload byte, used at start
// - control bits six and two reserved
// - third timer underflow sets its flag
// - third timer clock select picks tick
//
// Chosen here: the APB interface to the registers.
`include "rct_timer_map.svh"
module rct_timers
  import rct_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              tick_13m56,
  input  wire logic              tick_212k,
  input  wire logic              t0_underflow,
  input  wire logic              t1_underflow,
  input  wire logic              tx_end,
  input  wire logic              rx_first_bits,
  input  wire logic              trim_edge,
  output logic                   timer2_underflow,
  output logic                   timer3_underflow,
  output logic                   irq
);
  rct_tmr_if t2_if ();
  rct_tmr_if t3_if ();

  logic [7:0]  timer2_control_ff;
  logic [7:0]  timer2_reload_upper_ff;
  logic [7:0]  timer2_reload_low_ff;
  logic [7:0]  timer3_control_ff;
  logic [7:0]  timer3_reload_high_ff;
  logic [7:0]  timer3_reload_low_ff;
  logic [1:0]  irq_status_ff;
  logic [1:0]  irq_mask_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_ff;
  logic        t2_uf_out_ff;
  logic        t3_uf_out_ff;
  logic [3:0]  cmd_ff;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        rd_done;
  logic [7:0]  idx;
  logic        addr_ok;
  logic [31:0] nxt_rdata;
  logic        nxt_hit;
  logic [1:0]  nxt_irq_status;

  // tick for the selected count clock
  function automatic logic sel_tick(input logic [1:0] sel,
                                    input logic t13, input logic t212,
                                    input logic u0, input logic u1);
    case (sel)
      `RCT_CLK_13M56: sel_tick = t13;
      `RCT_CLK_212K:  sel_tick = t212;
      `RCT_CLK_T0_UF: sel_tick = u0;
      default:        sel_tick = u1;
    endcase
  endfunction

  // both trimming codes share the top bit of the start field
  function automatic logic is_trim(input logic [7:0] ctl);
    is_trim = ctl[`RCT_CTL_START_HI];
  endfunction

  // start event: command, end of transmission, or trim edge while idle;
  // event lines come in as arguments so the calling assigns follow them
  function automatic logic start_evt(input logic [7:0] ctl,
                                     input logic cmd, input logic run,
                                     input logic txe, input logic trim);
    logic [1:0] mode;
    mode = ctl[`RCT_CTL_START_HI:`RCT_CTL_START_LO];
    start_evt = cmd || (mode == `RCT_START_TX_END && txe) ||
                (is_trim(ctl) && trim && !run);
  endfunction

  // stop event: command, receive progress, or trim edge while running
  function automatic logic stop_evt(input logic [7:0] ctl,
                                    input logic cmd, input logic run,
                                    input logic rx, input logic trim);
    stop_evt = cmd ||
      (ctl[`RCT_CTL_STOP_RX] && !is_trim(ctl) && rx && run) ||
      (is_trim(ctl) && trim && run);
  endfunction

  // apb phases; access completes in the cycle after setup
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready_ff;
  assign wr_en   = access && pwrite && !pslverr_ff;
  assign rd_done = access && !pwrite && !pslverr_ff &&
                   (idx == `RCT_IDX_IRQ_STATUS);
  assign addr_ok = (paddr[1:0] == 2'h0);
  assign idx     = 8'(paddr >> 2);

  // read mux and address decode, evaluated during setup
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_hit   = 1'b1;
    case (idx)
      `RCT_IDX_T2_CONTROL:      nxt_rdata[7:0] = timer2_control_ff;
      `RCT_IDX_T2_RELOAD_UPPER: nxt_rdata[7:0] = timer2_reload_upper_ff;
      `RCT_IDX_T2_RELOAD_LOW:   nxt_rdata[7:0] = timer2_reload_low_ff;
      `RCT_IDX_T2_COUNT_HIGH:   nxt_rdata[7:0] = t2_if.count[15:8];
      `RCT_IDX_T2_COUNT_LOW:    nxt_rdata[7:0] = t2_if.count[7:0];
      `RCT_IDX_T3_CONTROL:      nxt_rdata[7:0] = timer3_control_ff;
      `RCT_IDX_T3_RELOAD_HIGH:  nxt_rdata[7:0] = timer3_reload_high_ff;
      `RCT_IDX_T3_RELOAD_LOW:   nxt_rdata[7:0] = timer3_reload_low_ff;
      `RCT_IDX_T3_COUNT_HIGH:   nxt_rdata[7:0] = t3_if.count[15:8];
      `RCT_IDX_T3_COUNT_LOW:    nxt_rdata[7:0] = t3_if.count[7:0];
      `RCT_IDX_IRQ_STATUS:      nxt_rdata[1:0] = irq_status_ff;
      `RCT_IDX_IRQ_MASK:        nxt_rdata[1:0] = irq_mask_ff;
      `RCT_IDX_COMMAND:         nxt_rdata      = 32'h0000_0000;
      default:                  nxt_hit        = 1'b0;
    endcase
    if (!addr_ok) begin
      nxt_hit = 1'b0;
    end
  end

  // read data and error latched at setup so outputs come from flops;
  // the count snapshot is taken one cycle before the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !nxt_hit;
      if (setup) begin
        prdata_ff <= nxt_hit ? nxt_rdata : 32'h0000_0000;
      end
    end
  end

  // timer configuration registers; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_control_ff      <= `RCT_RST_BYTE;
      timer2_reload_upper_ff <= `RCT_RST_BYTE;
      timer2_reload_low_ff   <= `RCT_RST_BYTE;
      timer3_control_ff      <= `RCT_RST_BYTE;
      timer3_reload_high_ff  <= `RCT_RST_BYTE;
      timer3_reload_low_ff   <= `RCT_RST_BYTE;
      irq_mask_ff            <= `RCT_RST_IRQ;
    end else if (wr_en) begin
      case (idx)
        `RCT_IDX_T2_CONTROL:
          timer2_control_ff <= pwdata[7:0] & `RCT_CTL_WRITE_MASK;
        `RCT_IDX_T2_RELOAD_UPPER: timer2_reload_upper_ff <= pwdata[7:0];
        `RCT_IDX_T2_RELOAD_LOW:   timer2_reload_low_ff <= pwdata[7:0];
        `RCT_IDX_T3_CONTROL:
          timer3_control_ff <= pwdata[7:0] & `RCT_CTL_WRITE_MASK;
        `RCT_IDX_T3_RELOAD_HIGH: timer3_reload_high_ff <= pwdata[7:0];
        `RCT_IDX_T3_RELOAD_LOW:  timer3_reload_low_ff <= pwdata[7:0];
        `RCT_IDX_IRQ_MASK:       irq_mask_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // software start and stop strobes, one cycle wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= 4'h0;
    end else begin
      cmd_ff <= (wr_en && idx == `RCT_IDX_COMMAND) ? pwdata[3:0] : 4'h0;
    end
  end

  // timer2 drive; reload word is loaded by the core only at a start or an auto reload
  assign t2_if.tick        = sel_tick(
    timer2_control_ff[`RCT_CTL_CLK_HI:`RCT_CTL_CLK_LO],
    tick_13m56, tick_212k, t0_underflow, t1_underflow);
  assign t2_if.start       = start_evt(timer2_control_ff,
    cmd_ff[`RCT_CMD_T2_START], t2_if.running, tx_end, trim_edge);
  assign t2_if.stop        = stop_evt(timer2_control_ff,
    cmd_ff[`RCT_CMD_T2_STOP], t2_if.running,
    rx_first_bits, trim_edge);
  assign t2_if.auto_reload = timer2_control_ff[`RCT_CTL_AUTO_RELOAD];
  assign t2_if.allow_uf    = timer2_control_ff[`RCT_CTL_START_HI:
    `RCT_CTL_START_LO] != `RCT_START_TRIM_NO_UF;
  assign t2_if.reload      = {timer2_reload_upper_ff, timer2_reload_low_ff};

  // timer3 drive, same scheme
  assign t3_if.tick        = sel_tick(
    timer3_control_ff[`RCT_CTL_CLK_HI:`RCT_CTL_CLK_LO],
    tick_13m56, tick_212k, t0_underflow, t1_underflow);
  assign t3_if.start       = start_evt(timer3_control_ff,
    cmd_ff[`RCT_CMD_T3_START], t3_if.running, tx_end, trim_edge);
  assign t3_if.stop        = stop_evt(timer3_control_ff,
    cmd_ff[`RCT_CMD_T3_STOP], t3_if.running,
    rx_first_bits, trim_edge);
  assign t3_if.auto_reload = timer3_control_ff[`RCT_CTL_AUTO_RELOAD];
  assign t3_if.allow_uf    = timer3_control_ff[`RCT_CTL_START_HI:
    `RCT_CTL_START_LO] != `RCT_START_TRIM_NO_UF;
  assign t3_if.reload      = {timer3_reload_high_ff, timer3_reload_low_ff};

  rct_down_counter u_timer2 (
    .pclk    (pclk),
    .presetn (presetn),
    .tmr     (t2_if)
  );

  rct_down_counter u_timer3 (
    .pclk    (pclk),
    .presetn (presetn),
    .tmr     (t3_if)
  );

  // sticky flags; only bits returned by the read are cleared, set wins
  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (rd_done) begin
      nxt_irq_status = irq_status_ff & ~prdata_ff[1:0];
    end
    if (t2_if.underflow) begin
      nxt_irq_status[`RCT_IRQ_T2_UF] = 1'b1;
    end
    if (t3_if.underflow) begin
      nxt_irq_status[`RCT_IRQ_T3_UF] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_ff <= `RCT_RST_IRQ;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  // interrupt level and underflow outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff       <= 1'b0;
      t2_uf_out_ff <= 1'b0;
      t3_uf_out_ff <= 1'b0;
    end else begin
      irq_ff       <= |(irq_status_ff & irq_mask_ff);
      t2_uf_out_ff <= t2_if.underflow;
      t3_uf_out_ff <= t3_if.underflow;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign irq              = irq_ff;
  assign timer2_underflow = t2_uf_out_ff;
  assign timer3_underflow = t3_uf_out_ff;

  sequence s_rx_stop_t3;
    timer3_control_ff[`RCT_CTL_STOP_RX] && !is_trim(timer3_control_ff) &&
    rx_first_bits && t3_if.running && !t3_if.start;
  endsequence

  sequence s_t3_uf_seen;
    t3_if.underflow ##1 irq_status_ff[`RCT_IRQ_T3_UF];
  endsequence

  a_rx_stops: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_stop_t3 |=> !t3_if.running)
    else $error("stop on receive did not stop timer");
  a_trim_ignores_rx: assert property (@(posedge pclk) disable iff (!presetn)
    is_trim(timer3_control_ff) && !trim_edge && t3_if.running &&
    cmd_ff == 4'h0 && !t3_if.tick |=> t3_if.running)
    else $error("trimming timer stopped without trim edge");
  a_t3_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    t3_if.underflow |-> s_t3_uf_seen)
    else $error("timer3 underflow flag not set");
  a_t2_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    t2_if.underflow |=> irq_status_ff[`RCT_IRQ_T2_UF])
    else $error("timer2 underflow flag not set");
  a_ctl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    timer3_control_ff[6] == 1'b0 && timer3_control_ff[2] == 1'b0)
    else $error("reserved control bits set");
  a_tx_start: assert property (@(posedge pclk) disable iff (!presetn)
    tx_end && timer3_control_ff[5:4] == `RCT_START_TX_END
    |=> t3_if.running && t3_if.count == $past(t3_if.reload))
    else $error("end of transmission did not start timer");
  a_no_uf_trim: assert property (@(posedge pclk) disable iff (!presetn)
    timer3_control_ff[5:4] == `RCT_START_TRIM_NO_UF ##1
    timer3_control_ff[5:4] == `RCT_START_TRIM_NO_UF |-> !t3_if.underflow)
    else $error("underflow in trimming without underflow");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_ff == |($past(irq_status_ff) & $past(irq_mask_ff)))
    else $error("interrupt output does not follow status and mask");
  a_count_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && idx == `RCT_IDX_T2_COUNT_LOW && addr_ok
    |=> prdata_ff[7:0] == $past(t2_if.count[7:0]) && pready_ff)
    else $error("count low byte read wrong");
endmodule

// >>> verif/rct_timers_bench.sv
// Purpose: self-checking bench for the reload countdown timers
// Assumes: APB slave answers by pready; event inputs are one-cycle pulses
// Notes:   counts are only read while no reception is going on
`include "rct_timer_map.svh"
module rct_timers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  ev      = 7'h00;
  logic        timer2_underflow;
  logic        timer3_underflow;
  logic        irq;
  int          miscompares = 0;
  int          checks_done = 0;
  int          uf2         = 0;
  int          uf3         = 0;

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  rct_timers #(.ADDR_W(8)) dut_u (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .tick_13m56       (ev[0]),
    .tick_212k        (ev[1]),
    .t0_underflow     (ev[2]),
    .t1_underflow     (ev[3]),
    .tx_end           (ev[4]),
    .rx_first_bits    (ev[5]),
    .trim_edge        (ev[6]),
    .timer2_underflow (timer2_underflow),
    .timer3_underflow (timer3_underflow),
    .irq              (irq)
  );

  // count underflow pulses; a stuck pulse shows as extra counts
  always @(posedge pclk) begin
    if (timer2_underflow === 1'b1) uf2++;
    if (timer3_underflow === 1'b1) uf3++;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one APB transfer; pready, prdata and pslverr are taken at the edge
  // that completes the access, and only then is the request released
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx[5:0], 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    chk(d, exp);
  endtask

  // command write, then let the strobe and the load land
  task automatic go(input logic [7:0] v);
    wr(8'h32, {24'h0, v});
    repeat (3) @(posedge pclk);
  endtask

  // n one-cycle pulses on event line b, spaced by one idle cycle
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge pclk);
      ev[b] <= 1'b1;
      @(posedge pclk);
      ev[b] <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic        e;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, access kinds, refused access
    for (int i = 'h19; i <= 'h22; i++) rdc(8'(i), 32'h0);
    apb(1'b0, 8'h05, 32'h0, d, e);
    chk(32'(e), 32'h1);
    chk(d, 32'h0);
    wr(8'h1E, 32'hFF);
    rdc(8'h1E, 32'hBB);
    wr(8'h21, 32'h55);
    rdc(8'h21, 32'h0);
    // timer2 one-shot from reload 2: underflow on the third tick
    wr(8'h1A, 32'h0);
    wr(8'h1B, 32'h02);
    wr(8'h19, 32'h0);
    wr(8'h31, 32'h3);
    go(8'h01);
    rdc(8'h1D, 32'h2);
    rdc(8'h1C, 32'h0);
    pulse(0, 2);
    rdc(8'h1D, 32'h0);
    chk(uf2, 32'd0);
    pulse(0, 1);
    chk(uf2, 32'd1);
    chk(32'(irq), 32'h1);
    rdc(8'h30, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rdc(8'h30, 32'h0);
    pulse(0, 2);
    rdc(8'h1D, 32'h0);
    chk(uf2, 32'd1);
    // a reload write only counts from the next start
    wr(8'h1B, 32'h05);
    rdc(8'h1D, 32'h0);
    go(8'h01);
    rdc(8'h1D, 32'h5);
    go(8'h02);
    // every clock select of both timers; the next tick line in turn is ignored
    wr(8'h1F, 32'h0);
    wr(8'h20, 32'h05);
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 4; c++) begin
        wr(t ? 8'h1E : 8'h19, 32'(c));
        go(t ? 8'h04 : 8'h01);
        pulse((c + 1) % 4, 1);
        pulse(c, 1);
        rdc(t ? 8'h22 : 8'h1D, 32'h4);
        go(t ? 8'h08 : 8'h02);
      end
    end
    // timer3 high reload byte and auto reload
    wr(8'h1F, 32'h01);
    wr(8'h20, 32'h00);
    wr(8'h1E, 32'h09);
    go(8'h04);
    rdc(8'h21, 32'h1);
    pulse(1, 1);
    rdc(8'h22, 32'hFF);
    go(8'h08);
    wr(8'h1F, 32'h0);
    wr(8'h20, 32'h01);
    rdc(8'h22, 32'hFF);
    go(8'h04);
    rdc(8'h22, 32'h1);
    pulse(1, 2);
    chk(uf3, 32'd1);
    rdc(8'h22, 32'h1);
    pulse(1, 2);
    chk(uf3, 32'd2);
    go(8'h08);
    rdc(8'h30, 32'h2);
    // stop-on-receive set, then clear
    for (int s = 1; s >= 0; s--) begin
      wr(8'h1E, s ? 32'h81 : 32'h01);
      go(8'h04);
      pulse(5, 1);
      pulse(1, 1);
      rdc(8'h22, s ? 32'h1 : 32'h0);
      go(8'h08);
    end
    // start modes: none, end of transmission, both trimming modes
    wr(8'h1E, 32'h01);
    pulse(4, 1);
    pulse(6, 1);
    rdc(8'h22, 32'h0);
    wr(8'h1E, 32'h11);
    pulse(4, 1);
    rdc(8'h22, 32'h1);
    go(8'h08);
    wr(8'h31, 32'h1);
    wr(8'h1E, 32'hA1);
    pulse(6, 1);
    pulse(5, 1);
    pulse(1, 2);
    rdc(8'h22, 32'h0);
    chk(uf3, 32'd2);
    wr(8'h1E, 32'hB1);
    pulse(6, 1);
    pulse(1, 2);
    chk(uf3, 32'd3);
    chk(32'(irq), 32'h0); // masked status keeps the line low
    rdc(8'h30, 32'h2);
    end_of_test();
  end
endmodule
